// file: src/csc_pkg.sv
// Constants, types and carriers of the cruise set-speed logic
package csc_pkg;
  // ==========================================================
  // Clock and timing
  localparam longint unsigned CLK_HZ       = 100_000_000;
  localparam longint unsigned GATE_TIME_MS = 100;
  localparam longint unsigned HOLD_TIME_S  = 25;
  localparam logic [31:0] GATE_CYC =
    32'((GATE_TIME_MS * CLK_HZ) / 1000);
  localparam logic [31:0] HOLD_CYC = 32'(HOLD_TIME_S * CLK_HZ);
  // ==========================================================
  // Speed figures in km/h, one speed pulse per gate is 1 km/h
  localparam logic [7:0] SPD_LOW  = 8'h28;
  localparam logic [7:0] SPD_HIGH = 8'h91;
  localparam logic [7:0] SPD_DROP = 8'h0f;
  localparam logic [7:0] OD_DROP  = 8'h07;
  localparam logic [7:0] SPD_MAX  = 8'hff;
  // ==========================================================
  // Throttle figures
  localparam logic [7:0] THR_CLIMB   = 8'h80;
  localparam logic [7:0] THR_RESTORE = 8'h40;
  localparam logic [7:0] STEP_FULL   = 8'hff;
  localparam int         GAIN_SHIFT  = 3;
  // ==========================================================
  // Reset values and diagnosis codes
  localparam logic [7:0]  SPD_RST   = 8'h00;
  localparam logic [7:0]  THR_RST   = 8'h00;
  localparam logic [31:0] CNT_RST   = 32'h0000_0000;
  localparam logic [4:0]  DIAG_NONE = 5'h00;
  localparam logic [4:0]  DIAG_SW   = 5'h0f;
  // ==========================================================
  // Types
  typedef enum logic [3:0] {
    ST_OFF    = 4'b0001,
    ST_IDLE   = 4'b0010,
    ST_CRUISE = 4'b0100,
    ST_COAST  = 4'b1000
  } csc_state_type;

  typedef struct packed {
    logic main;
    logic set;
    logic resume;
    logic cancel;
    logic brake;
    logic clutch_neutral;
    logic idle;
    logic auto_trans;
  } csc_sw_type;

  typedef struct packed {
    logic       open;
    logic       close;
    logic [7:0] step;
  } csc_act_type;

  typedef struct packed {
    logic power;
    logic active;
  } csc_lamp_type;
endpackage

// file: src/csc_setpoint.sv
// Cruise speed setpoint, mode and actuator command logic
// How it works
// [R1] Set switch on-to-off inside 40-145 km/h captures speed as set speed
// [R2] With a set speed, actuator is driven continuously toward it
// [R3] Release above 145 km/h stores 145 km/h instead
// [R4] Set switch held during cruise: coast, throttle fully closed
// [R5] Set release ending coast stores speed at that moment
// [R6] Speed below 40 km/h during coast aborts coast
// [R7] That abort stores the speed recorded just before coast began
// [R8] Power lamp lit whenever the main switch has power on
// [R9] Active lamp lit only while regulation runs
// [R10] Correction size scales with speed and throttle opening
// [R11] Automatic: release top gear climbing, restore by speed and throttle
// [R12] Cancel, brake, clutch or neutral input cancels regulation
// [R13] Diagnosis code and input condition shown on a diagnosis line
// [R14] Throttle at idle switch on-to-off is the offset reference
// [R15] Speed more than 15 km/h below set speed cancels (the code checks this in cruise only, not in coast)
// [R16] Set, resume or cancel held 25 s is a fault and cancels
// [R17] Speed is speed pulses counted over a fixed clock window
module csc_setpoint
#(
  parameter logic [31:0] GATE_CYCLES = csc_pkg::GATE_CYC,
  parameter logic [31:0] HOLD_CYCLES = csc_pkg::HOLD_CYC
)
(
  // Clock and reset
  input  logic                  clk,
  input  logic                  rst,
  // Switches and sensors
  input  csc_pkg::csc_sw_type   sw_pin,
  input  logic                  speed_pulse,
  input  logic [7:0]            throttle_opening_sensor,
  // Actuator and gear
  output csc_pkg::csc_act_type  act_q,
  output logic                  od_release_q,
  // Indicators and diagnosis
  output csc_pkg::csc_lamp_type lamp_q,
  output logic [4:0]            diag_code_q,
  output logic                  diag_line_q
);
  import csc_pkg::*;

  // ==========================================================
  // Input synchronisers
  csc_sw_type    sw_meta_q;
  csc_sw_type    sw_q;
  csc_sw_type    sw_prev_q;
  logic          pulse_meta_q;
  logic          pulse_q;
  logic          pulse_prev_q;
  logic [7:0]    thr_meta_q;
  logic [7:0]    thr_q;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sw_meta_q    <= '0;
      sw_q         <= '0;
      sw_prev_q    <= '0;
      pulse_meta_q <= 1'b0;
      pulse_q      <= 1'b0;
      pulse_prev_q <= 1'b0;
      thr_meta_q   <= THR_RST;
      thr_q        <= THR_RST;
    end
    else
    begin
      sw_meta_q    <= sw_pin;
      sw_q         <= sw_meta_q;
      sw_prev_q    <= sw_q;
      pulse_meta_q <= speed_pulse;
      pulse_q      <= pulse_meta_q;
      pulse_prev_q <= pulse_q;
      thr_meta_q   <= throttle_opening_sensor;
      thr_q        <= thr_meta_q;
    end
  end
  logic set_fall;
  logic idle_fall;
  logic pulse_rise;
  logic held;
  logic cancel_in;
  assign set_fall   = sw_prev_q.set & ~sw_q.set;
  assign idle_fall  = sw_prev_q.idle & ~sw_q.idle;
  assign pulse_rise = pulse_q & ~pulse_prev_q;
  assign held       = sw_q.set | sw_q.resume | sw_q.cancel;

  // ==========================================================
  // Speed measurement and throttle reference
  logic [31:0] gate_q, gate_d;
  logic [7:0]  pcnt_q, pcnt_d;
  logic [7:0]  speed_q, speed_d;
  logic [7:0]  thr_ref_q, thr_ref_d;
  logic [7:0]  thr_comp;
  always_comb
  begin
    gate_d    = gate_q + 32'h1;
    pcnt_d    = pcnt_q;
    speed_d   = speed_q;
    thr_ref_d = thr_ref_q;
    if (pulse_rise && pcnt_q != SPD_MAX)
      pcnt_d = pcnt_q + 8'h1;
    if (gate_q >= GATE_CYCLES - 32'h1)
    begin
      gate_d  = CNT_RST;
      speed_d = pcnt_q; // see [R17]
      pcnt_d  = {7'h00, pulse_rise};
    end
    if (idle_fall)
      thr_ref_d = thr_q; // see [R14]
  end
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      gate_q    <= CNT_RST;
      pcnt_q    <= SPD_RST;
      speed_q   <= SPD_RST;
      thr_ref_q <= THR_RST;
    end
    else
    begin
      gate_q    <= gate_d;
      pcnt_q    <= pcnt_d;
      speed_q   <= speed_d;
      thr_ref_q <= thr_ref_d;
    end
  end
  // Offset-compensated throttle opening
  assign thr_comp = (thr_q > thr_ref_q) ? thr_q - thr_ref_q : '0; // see [R14]

  // ==========================================================
  // Stuck switch watchdog
  logic [31:0] hold_q, hold_d;
  logic        fault_q, fault_d;
  logic        hold_hit;
  assign hold_hit = held && (hold_q >= HOLD_CYCLES - 32'h1);
  always_comb
  begin
    hold_d = CNT_RST;
    if (held && !hold_hit)
      hold_d = hold_q + 32'h1;
    else if (held)
      hold_d = hold_q;
    fault_d = hold_hit | (fault_q & sw_q.main); // see [R16]
  end
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      hold_q  <= CNT_RST;
      fault_q <= 1'b0;
    end
    else
    begin
      hold_q  <= hold_d;
      fault_q <= fault_d;
    end
  end

  // ==========================================================
  // Mode state machine and set speed
  csc_state_type st_q, st_d;
  logic [7:0]    set_q, set_d;
  logic [7:0]    cref_q, cref_d;
  logic          low_drop;
  assign cancel_in = sw_q.cancel | sw_q.brake | sw_q.clutch_neutral
                   | fault_q | hold_hit; // see [R12] [R16]
  assign low_drop  = ({1'b0, speed_q} + {1'b0, SPD_DROP})
                   < {1'b0, set_q}; // see [R15]
  always_comb
  begin
    st_d   = st_q;
    set_d  = set_q;
    cref_d = cref_q;
    case (st_q)
      ST_OFF:
        st_d = ST_IDLE;
      ST_IDLE:
        if (set_fall && speed_q >= SPD_LOW && !cancel_in)
        begin
          set_d = (speed_q > SPD_HIGH) ? SPD_HIGH : speed_q; // see [R1] [R3]
          st_d  = ST_CRUISE;
        end
      ST_CRUISE:
        if (cancel_in || low_drop)
          st_d = ST_IDLE; // see [R12] [R15]
        else if (sw_q.set)
        begin
          cref_d = speed_q;
          st_d   = ST_COAST; // see [R4]
        end
      ST_COAST:
        if (cancel_in)
          st_d = ST_IDLE;
        else if (speed_q < SPD_LOW)
        begin
          set_d = cref_q; // see [R6] [R7]
          st_d  = ST_IDLE;
        end
        else if (set_fall)
        begin
          set_d = (speed_q > SPD_HIGH) ? SPD_HIGH : speed_q; // see [R5]
          st_d  = ST_CRUISE;
        end
      default:
        st_d = ST_OFF;
    endcase
    if (!sw_q.main)
      st_d = ST_OFF;
  end
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_q   <= ST_OFF;
      set_q  <= SPD_RST;
      cref_q <= SPD_RST;
    end
    else
    begin
      st_q   <= st_d;
      set_q  <= set_d;
      cref_q <= cref_d;
    end
  end
  // ==========================================================
  // Registered outputs
  csc_act_type  act_d;
  csc_lamp_type lamp_d;
  logic         od_d;
  logic [4:0]   diag_code_d;
  logic         diag_line_d;
  logic [8:0]   gain;
  assign gain = {1'b0, speed_q >> GAIN_SHIFT}
              + {1'b0, thr_comp >> GAIN_SHIFT} + 9'h001; // see [R10]
  always_comb
  begin
    act_d = '0;
    case (st_q)
      ST_CRUISE:
      begin
        act_d.open  = speed_q < set_q; // see [R2]
        act_d.close = speed_q > set_q;
        act_d.step  = gain[8] ? STEP_FULL : gain[7:0]; // see [R10]
      end
      ST_COAST:
      begin
        act_d.close = 1'b1; // see [R4]
        act_d.step  = STEP_FULL;
      end
      default:
        act_d = '0;
    endcase
    od_d = od_release_q;
    if (!(st_q == ST_CRUISE || st_q == ST_COAST) || !sw_q.auto_trans)
      od_d = 1'b0;
    else if (!od_release_q && thr_comp >= THR_CLIMB
             && ({1'b0, speed_q} + {1'b0, OD_DROP}) <= {1'b0, set_q})
      od_d = 1'b1; // see [R11]
    else if (od_release_q && speed_q >= set_q
             && thr_comp < THR_RESTORE)
      od_d = 1'b0; // see [R11]
    lamp_d.power  = st_q != ST_OFF; // see [R8]
    lamp_d.active = st_q == ST_CRUISE || st_q == ST_COAST; // see [R9]
    diag_code_d   = fault_q ? DIAG_SW : DIAG_NONE; // see [R13]
    diag_line_d   = fault_q | held | sw_q.brake | sw_q.clutch_neutral;
  end
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      act_q        <= '0;
      od_release_q <= 1'b0;
      lamp_q       <= '0;
      diag_code_q  <= DIAG_NONE;
      diag_line_q  <= 1'b0;
    end
    else
    begin
      act_q        <= act_d;
      od_release_q <= od_d;
      lamp_q       <= lamp_d;
      diag_code_q  <= diag_code_d;
      diag_line_q  <= diag_line_d;
    end
  end
  // ==========================================================
  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  chk_set_capture: assert property ( // see [R1]
    st_q == ST_IDLE && set_fall && !cancel_in && sw_q.main
    && speed_q >= SPD_LOW && speed_q <= SPD_HIGH
    |=> st_q == ST_CRUISE && set_q == $past(speed_q))
    else $error("set speed not captured");
  chk_high_clamp: assert property ( // see [R3]
    st_q == ST_IDLE && set_fall && !cancel_in && sw_q.main
    && speed_q > SPD_HIGH |=> set_q == SPD_HIGH)
    else $error("high limit not stored");
  chk_coast_close: assert property ( // see [R4]
    st_q == ST_CRUISE && sw_q.set && !cancel_in && !low_drop
    && sw_q.main |=> ##1 act_q.close && act_q.step == STEP_FULL)
    else $error("coast did not close throttle");
  chk_coast_release: assert property ( // see [R5]
    st_q == ST_COAST && set_fall && !cancel_in && sw_q.main
    && speed_q >= SPD_LOW && speed_q <= SPD_HIGH
    |=> set_q == $past(speed_q) && st_q == ST_CRUISE)
    else $error("coast release speed not stored");
  chk_coast_abort: assert property ( // see [R7]
    st_q == ST_COAST && speed_q < SPD_LOW && !cancel_in
    && sw_q.main |=> st_q == ST_IDLE && set_q == $past(cref_q))
    else $error("coast abort speed wrong");
  chk_cancel_stop: assert property ( // see [R12]
    lamp_d.active && cancel_in && sw_q.main
    |=> st_q == ST_IDLE ##1 !lamp_q.active && !act_q.open)
    else $error("cancel did not stop regulation");
  chk_drop_cancel: assert property ( // see [R15]
    st_q == ST_CRUISE && low_drop && sw_q.main |=> st_q == ST_IDLE)
    else $error("speed drop did not cancel");
  chk_hold_fault: assert property ( // see [R16]
    hold_hit && sw_q.main |=> fault_q ##1 diag_code_q == DIAG_SW)
    else $error("stuck switch not flagged");
  chk_idle_ref: assert property ( // see [R14]
    idle_fall |=> thr_ref_q == $past(thr_q))
    else $error("throttle reference not taken");
  chk_power_lamp: assert property ( // see [R8]
    !sw_q.main |=> ##1 !lamp_q.power)
    else $error("power lamp lit with main off");
  cov_cruise_set: cover property (
    st_q == ST_IDLE ##1 st_q == ST_CRUISE);
  cov_coast_done: cover property (
    st_q == ST_COAST ##1 st_q == ST_CRUISE);
  cov_od_release: cover property (!od_release_q ##1 od_release_q);
endmodule

// file: testbench/csc_road_model.sv
// Road model: speed sensor pulses at a chosen speed
module csc_road_model
#(
  parameter int WIN = 400
)
(
  // Clock
  input  logic       clk,
  // Wanted speed in km/h
  input  logic [7:0] speed,
  // Sensor pulse
  output logic       speed_pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  int phase = 0;
  initial speed_pulse = 1'b0;
  // ==========================================================
  // Pattern repeats every WIN clocks, so any window sees speed edges while speed is at most WIN/2
  always @(posedge clk)
  begin
    phase       <= (phase == WIN - 1) ? 0 : phase + 1;
    speed_pulse <= #1 (phase < 2 * speed) && phase[0];
  end
endmodule

// file: testbench/tb_top.sv
// Testbench of the cruise set-speed logic
module tb_top
  import csc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] WIN  = 32'h0000_0190;
  localparam logic [31:0] HOLD = 32'h0000_07d0;
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  csc_sw_type   sw  = 8'h01;
  logic [7:0]   spd = 8'h00;
  logic [7:0]   thr = 8'h00;
  logic         pulse;
  csc_act_type  act;
  logic         od;
  csc_lamp_type lamp;
  logic [4:0]   dcode;
  logic         dline;
  int           err_count = 0;
  int           tests_run = 0;
  // ==========================================================
  // Design and road model
  csc_setpoint
  #(
    .GATE_CYCLES (WIN),
    .HOLD_CYCLES (HOLD)
  )
  dut
  (
    .clk                     (clk),
    .rst                     (rst),
    .sw_pin                  (sw),
    .speed_pulse             (pulse),
    .throttle_opening_sensor (thr),
    .act_q                   (act),
    .od_release_q            (od),
    .lamp_q                  (lamp),
    .diag_code_q             (dcode),
    .diag_line_q             (dline)
  );
  csc_road_model
  #(
    .WIN (WIN)
  )
  road
  (
    .clk         (clk),
    .speed       (spd),
    .speed_pulse (pulse)
  );
  initial
  begin
    forever #5 clk = ~clk;
  end
  // ==========================================================
  // Tasks
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    tests_run++;
    if (g !== e)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic logic [7:0] dir();
    return {6'h00, act.open, act.close};
  endfunction
  task automatic set_spd(input logic [7:0] v);
    spd = v;
    tick(3 * WIN + 10);
  endtask
  task automatic wait_act(input logic e);
    int i;
    for (i = 0; i < 100 && lamp.active !== e; i++)
      tick(1);
    chk("active lamp", {7'h00, e}, {7'h00, lamp.active});
    if (lamp.active !== e)
      give_verdict();
  endtask
  task automatic cruise_at(input logic [7:0] v);
    set_spd(v);
    sw.set = 1'b1;
    tick(20);
    sw.set = 1'b0;
    wait_act(1'b1);
  endtask
  // ==========================================================
  // Sequence
  initial
  begin
    tick(6);
    rst = 1'b0;
    tick(2);
    chk("dir", 8'h00, dir());
    chk("step", 8'h00, act.step);
    sw.main = 1'b1;
    tick(8);
    chk("power lamp", 8'h01, {7'h00, lamp.power});
    chk("diag line", 8'h00, {7'h00, dline});
    chk("diag code", 8'h00, {3'h0, dcode});
    set_spd(8'h1e);
    sw.set = 1'b1;
    tick(20);
    sw.set = 1'b0;
    tick(20);
    chk("active lamp", 8'h00, {7'h00, lamp.active});
    cruise_at(8'h3c);
    chk("dir", 8'h00, dir());
    set_spd(8'h37);
    chk("dir", 8'h02, dir());
    chk("step", 8'h07, act.step);
    set_spd(8'h41);
    chk("dir", 8'h01, dir());
    chk("step", 8'h09, act.step);
    sw.idle = 1'b1;
    thr = 8'h20;
    tick(10);
    sw.idle = 1'b0;
    tick(10);
    thr = 8'ha0;
    set_spd(8'h35);
    chk("gear release", 8'h01, {7'h00, od});
    chk("step", 8'h17, act.step);
    thr = 8'h30;
    set_spd(8'h3c);
    chk("gear release", 8'h00, {7'h00, od});
    set_spd(8'h2d);
    chk("active lamp", 8'h01, {7'h00, lamp.active});
    spd = 8'h2c;
    tick(3 * WIN);
    wait_act(1'b0);
    // Coast down from 60 to 50, then abort below 40
    cruise_at(8'h3c);
    sw.set = 1'b1;
    tick(10);
    chk("dir", 8'h01, dir());
    chk("step", 8'hff, act.step);
    set_spd(8'h32);
    sw.set = 1'b0;
    tick(10);
    chk("dir", 8'h00, dir());
    sw.set = 1'b1;
    set_spd(8'h23);
    wait_act(1'b0);
    sw.set = 1'b0;
    tick(10);
    cruise_at(8'h96);
    chk("dir", 8'h01, dir());
    set_spd(8'h91);
    chk("dir", 8'h00, dir());
    // Cancel, brake and clutch or neutral in turn
    for (int k = 0; k < 3; k++)
    begin
      cruise_at(8'h3c);
      sw[4 - k] = 1'b1;
      wait_act(1'b0);
      chk("diag line", 8'h01, {7'h00, dline});
      sw[4 - k] = 1'b0;
      tick(10);
    end
    cruise_at(8'h3c);
    sw.resume = 1'b1;
    tick(int'(HOLD) - 20);
    chk("active lamp", 8'h01, {7'h00, lamp.active});
    tick(20);
    wait_act(1'b0);
    chk("diag code", 8'h0f, {3'h0, dcode});
    sw.resume = 1'b0;
    sw.main = 1'b0;
    tick(10);
    chk("power lamp", 8'h00, {7'h00, lamp.power});
    chk("diag code", 8'h00, {3'h0, dcode});
    give_verdict();
  end
endmodule
